// >>> inc/tccu_defines.vh
// register offsets, field positions and reset values of the timer capture/compare unit
// assumes a wishbone byte address with one register per 32-bit word, all word-aligned except CLRTGL at 8'hef
`ifndef TCCU_DEFINES_VH
`define TCCU_DEFINES_VH
// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define TCCU_OFS_FLAGS 8'hc8
`define TCCU_OFS_CLRTGL 8'hef
`define TCCU_OFS_EDGE 8'h00
`define TCCU_OFS_SETEN 8'h04
`define TCCU_OFS_CTRL 8'h08
`define TCCU_OFS_MASK 8'h0c
`define TCCU_OFS_PORT 8'h10
`define TCCU_OFS_TMR_LO 8'h14
`define TCCU_OFS_TMR_HI 8'h18
`define TCCU_OFS_CMP_A 8'h20
`define TCCU_OFS_CMP_B 8'h24
`define TCCU_OFS_CMP_C 8'h28
`define TCCU_OFS_CAP0 8'h30
`define TCCU_OFS_CAP1 8'h34
`define TCCU_OFS_CAP2 8'h38
`define TCCU_OFS_CAP3 8'h3c
// ----------------------------------------
// field positions
// ----------------------------------------
`define TCCU_FLG_WRAP 7
`define TCCU_FLG_CMP_C 6
`define TCCU_FLG_CMP_B 5
`define TCCU_FLG_CMP_A 4
`define TCCU_CTL_WRAP_SEL 7
`define TCCU_CTL_LOW_SEL 6
`define TCCU_CTL_LOW_FLAG 4
`define TCCU_CTL_RUN 0
// ----------------------------------------
// reset values
// ----------------------------------------
`define TCCU_RST_BYTE 8'h00
`define TCCU_RST_WORD 16'h0000
`endif

// >>> logic/tccu_top.v
// timer capture/compare unit: 16-bit free-running timer, four captures, three compares
// assumes a classic wishbone master on CLK, synchronous capture inputs, SRST active high
`include "tccu_defines.vh"
`timescale 1ns/1ns
`default_nettype none
module tccu_top #(
   parameter TW = 16,
   parameter NCAP = 4
)(
   // clock, reset, enable
   input wire CLK,
   input wire SRST,
   input wire CE,
   // wishbone slave
   input wire WB_CYC_I,
   input wire WB_STB_I,
   input wire WB_WE_I,
   input wire [7:0] WB_ADR_I,
   input wire [3:0] WB_SEL_I,
   input wire [31:0] WB_DAT_I,
   output reg [31:0] WB_DAT_O,
   output reg WB_ACK_O,
   // capture inputs
   input wire [NCAP-1:0] CAPTURE_IN,
   // port-4 outputs and interrupt
   output reg [7:0] PORT4_OUT,
   output reg IRQ
);
   // ----------------------------------------
   // registers
   // ----------------------------------------
   reg [7:0] edge_q, seten_q, clrtgl_q, ctrl_q, mask_q, flags_q;
   reg [TW-1:0] timer_q, cmp_a_q, cmp_b_q, cmp_c_q;
   reg [TW-1:0] cap_q [0:NCAP-1];
   reg [NCAP-1:0] cin_q;
   reg eq_a_q, eq_b_q, eq_c_q;
   wire wr = WB_CYC_I & WB_STB_I & WB_WE_I & ~WB_ACK_O & WB_SEL_I[0];
   wire rd_ok = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
   wire [7:0] wd = WB_DAT_I[7:0];
   // ----------------------------------------
   // timer and event detection
   // ----------------------------------------
   wire run = ctrl_q[`TCCU_CTL_RUN];
   wire [TW-1:0] timer_d = timer_q + {{(TW-1){1'b0}}, 1'b1};
   wire low_wrap = run & (timer_q[7:0] == 8'hff);
   wire full_wrap = run & (&timer_q);
   // equality level; an event fires only on the cycle it begins
   wire eq_a = (timer_q == cmp_a_q);
   wire eq_b = (timer_q == cmp_b_q);
   wire eq_c = (timer_q == cmp_c_q);
   wire hit_a = eq_a & ~eq_a_q;
   wire hit_b = eq_b & ~eq_b_q;
   wire hit_c = eq_c & ~eq_c_q;
   wire [NCAP-1:0] cap_hit;
   genvar g;
   generate
      for (g = 0; g < NCAP; g = g + 1)
      begin : g_cap
         wire rise = CAPTURE_IN[g] & ~cin_q[g];
         wire fall = ~CAPTURE_IN[g] & cin_q[g];
         // no enabled edge: neither capture nor flag
         assign cap_hit[g] = (rise & edge_q[2*g]) | (fall & edge_q[2*g+1]);
         always @(posedge CLK)
         begin
            if (SRST)
               cap_q[g] <= `TCCU_RST_WORD;
            else if (CE && cap_hit[g])
               cap_q[g] <= timer_q;
         end
      end
   endgenerate
   // ----------------------------------------
   // port-4 action logic
   // ----------------------------------------
   reg [7:0] port_d;
   always @*
   begin
      port_d = PORT4_OUT;
      // software writes go first so compare actions in the same cycle still land
      if (wr && WB_ADR_I == `TCCU_OFS_PORT)
         port_d = wd;
      if (hit_a)
         port_d[5:0] = port_d[5:0] | seten_q[5:0];
      if (hit_b)
         port_d[5:0] = port_d[5:0] & ~clrtgl_q[5:0];
      if (hit_c)
      begin
         if (clrtgl_q[6])
            port_d[6] = ~seten_q[6];
         if (clrtgl_q[7])
            port_d[7] = ~seten_q[7];
      end
   end
   // ----------------------------------------
   // flags: set wins over write-one-to-clear
   // ----------------------------------------
   wire [7:0] flag_set = {full_wrap, hit_c, hit_b, hit_a, cap_hit};
   wire [7:0] flag_clr = (wr && WB_ADR_I == `TCCU_OFS_FLAGS) ? wd : 8'h00;
   wire low_clr = wr && WB_ADR_I == `TCCU_OFS_CTRL && wd[`TCCU_CTL_LOW_FLAG];
   // full wrap only interrupts when selected; low-byte wrap likewise
   wire [7:0] irq_src = {flags_q[7] & ctrl_q[`TCCU_CTL_WRAP_SEL], flags_q[6:0]};
   wire irq_d = (|(irq_src & mask_q)) |
                (ctrl_q[`TCCU_CTL_LOW_FLAG] & ctrl_q[`TCCU_CTL_LOW_SEL]);
   // ----------------------------------------
   // read mux
   // ----------------------------------------
   reg [7:0] rd_d;
   always @*
   begin
      case (WB_ADR_I)
         `TCCU_OFS_FLAGS: rd_d = flags_q;
         `TCCU_OFS_CLRTGL: rd_d = clrtgl_q;
         `TCCU_OFS_EDGE: rd_d = edge_q;
         `TCCU_OFS_SETEN: rd_d = seten_q;
         `TCCU_OFS_CTRL: rd_d = ctrl_q;
         `TCCU_OFS_MASK: rd_d = mask_q;
         `TCCU_OFS_PORT: rd_d = PORT4_OUT;
         `TCCU_OFS_TMR_LO: rd_d = timer_q[7:0];
         `TCCU_OFS_TMR_HI: rd_d = timer_q[15:8];
         `TCCU_OFS_CMP_A: rd_d = cmp_a_q[7:0];
         `TCCU_OFS_CMP_B: rd_d = cmp_b_q[7:0];
         `TCCU_OFS_CMP_C: rd_d = cmp_c_q[7:0];
         `TCCU_OFS_CAP0: rd_d = cap_q[0][7:0];
         `TCCU_OFS_CAP1: rd_d = cap_q[1][7:0];
         `TCCU_OFS_CAP2: rd_d = cap_q[2][7:0];
         `TCCU_OFS_CAP3: rd_d = cap_q[3][7:0];
         default: rd_d = 8'h00;
      endcase
   end
   // upper bytes of the compare and capture registers sit in data bits 15:8
   reg [7:0] rd_hi;
   always @*
   begin
      case (WB_ADR_I)
         `TCCU_OFS_CMP_A: rd_hi = cmp_a_q[15:8];
         `TCCU_OFS_CMP_B: rd_hi = cmp_b_q[15:8];
         `TCCU_OFS_CMP_C: rd_hi = cmp_c_q[15:8];
         `TCCU_OFS_CAP0: rd_hi = cap_q[0][15:8];
         `TCCU_OFS_CAP1: rd_hi = cap_q[1][15:8];
         `TCCU_OFS_CAP2: rd_hi = cap_q[2][15:8];
         `TCCU_OFS_CAP3: rd_hi = cap_q[3][15:8];
         default: rd_hi = 8'h00;
      endcase
   end

   // ----------------------------------------
   // write strobes
   // ----------------------------------------
   // byte lane 1 only matters for the 16-bit compare registers
   wire wr_hi = WB_CYC_I & WB_STB_I & WB_WE_I & ~WB_ACK_O & WB_SEL_I[1];
   wire wr_edge = wr && (WB_ADR_I == `TCCU_OFS_EDGE);
   wire wr_seten = wr && (WB_ADR_I == `TCCU_OFS_SETEN);
   wire wr_clrtgl = wr && (WB_ADR_I == `TCCU_OFS_CLRTGL);
   wire wr_mask = wr && (WB_ADR_I == `TCCU_OFS_MASK);
   wire wr_ctrl = wr && (WB_ADR_I == `TCCU_OFS_CTRL);
   wire sel_a = (WB_ADR_I == `TCCU_OFS_CMP_A);
   wire sel_b = (WB_ADR_I == `TCCU_OFS_CMP_B);
   wire sel_c = (WB_ADR_I == `TCCU_OFS_CMP_C);

   // ----------------------------------------
   // configuration registers
   // ----------------------------------------
   // edge enables: even bit rising, odd bit falling
   always @(posedge CLK)
   begin
      if (SRST)
         edge_q <= `TCCU_RST_BYTE;
      else if (CE && wr_edge)
         edge_q <= wd;
   end

   // set enables for bits 0-5, toggle result for bits 6,7
   always @(posedge CLK)
   begin
      if (SRST)
         seten_q <= `TCCU_RST_BYTE;
      else if (CE && wr_seten)
         seten_q <= wd;
   end

   // clear enables for bits 0-5, toggle enables for bits 6,7
   always @(posedge CLK)
   begin
      if (SRST)
         clrtgl_q <= `TCCU_RST_BYTE;
      else if (CE && wr_clrtgl)
         clrtgl_q <= wd;
   end

   // mask gates the flag bits onto the interrupt line
   always @(posedge CLK)
   begin
      if (SRST)
         mask_q <= `TCCU_RST_BYTE;
      else if (CE && wr_mask)
         mask_q <= wd;
   end

   // ----------------------------------------
   // control and low-byte wrap flag
   // ----------------------------------------
   // the low-byte flag is write-one-to-clear, so it keeps its own term
   always @(posedge CLK)
   begin
      if (SRST)
         ctrl_q <= `TCCU_RST_BYTE;
      else if (CE)
      begin
         if (wr_ctrl)
         begin
            ctrl_q[7:5] <= wd[7:5];
            ctrl_q[3:0] <= wd[3:0];
         end
         // hardware set wins over a clear in the same cycle
         ctrl_q[`TCCU_CTL_LOW_FLAG] <= low_wrap |
            (ctrl_q[`TCCU_CTL_LOW_FLAG] & ~low_clr);
      end
   end

   // ----------------------------------------
   // event flags
   // ----------------------------------------
   // set wins over write-one-to-clear, so no event is ever lost
   always @(posedge CLK)
   begin
      if (SRST)
         flags_q <= `TCCU_RST_BYTE;
      else if (CE)
         flags_q <= (flags_q & ~flag_clr) | flag_set;
   end

   // ----------------------------------------
   // timer
   // ----------------------------------------
   // not loadable by software; only reset restarts it from zero
   always @(posedge CLK)
   begin
      if (SRST)
         timer_q <= `TCCU_RST_WORD;
      else if (CE && run)
         timer_q <= timer_d;
   end

   // ----------------------------------------
   // compare registers
   // ----------------------------------------
   // a half-written value can match early; write both lanes at once
   always @(posedge CLK)
   begin
      if (SRST)
         cmp_a_q <= `TCCU_RST_WORD;
      else if (CE)
      begin
         if (wr && sel_a)
            cmp_a_q[7:0] <= wd;
         if (wr_hi && sel_a)
            cmp_a_q[15:8] <= WB_DAT_I[15:8];
      end
   end

   always @(posedge CLK)
   begin
      if (SRST)
         cmp_b_q <= `TCCU_RST_WORD;
      else if (CE)
      begin
         if (wr && sel_b)
            cmp_b_q[7:0] <= wd;
         if (wr_hi && sel_b)
            cmp_b_q[15:8] <= WB_DAT_I[15:8];
      end
   end

   always @(posedge CLK)
   begin
      if (SRST)
         cmp_c_q <= `TCCU_RST_WORD;
      else if (CE)
      begin
         if (wr && sel_c)
            cmp_c_q[7:0] <= wd;
         if (wr_hi && sel_c)
            cmp_c_q[15:8] <= WB_DAT_I[15:8];
      end
   end

   // ----------------------------------------
   // edge and equality history
   // ----------------------------------------
   // equality taken as present after reset, so zero matches only after a wrap
   // capture history resets to the idle low level, so no false edge follows
   always @(posedge CLK)
   begin
      if (SRST)
      begin
         cin_q <= {NCAP{1'b0}};
         eq_a_q <= 1'b1;
         eq_b_q <= 1'b1;
         eq_c_q <= 1'b1;
      end
      else if (CE)
      begin
         cin_q <= CAPTURE_IN;
         eq_a_q <= eq_a;
         eq_b_q <= eq_b;
         eq_c_q <= eq_c;
      end
   end

   // ----------------------------------------
   // registered outputs
   // ----------------------------------------
   always @(posedge CLK)
   begin
      if (SRST)
         PORT4_OUT <= `TCCU_RST_BYTE;
      else if (CE)
         PORT4_OUT <= port_d;
   end

   // one cycle behind the flags; software must allow for it
   always @(posedge CLK)
   begin
      if (SRST)
         IRQ <= 1'b0;
      else if (CE)
         IRQ <= irq_d;
   end

   // fixed one-cycle answer; the ack-low term keeps a request from repeating
   always @(posedge CLK)
   begin
      if (SRST)
      begin
         WB_ACK_O <= 1'b0;
         WB_DAT_O <= 32'h00000000;
      end
      else if (CE)
      begin
         WB_ACK_O <= rd_ok;
         WB_DAT_O <= {16'h0000, rd_hi, rd_d};
      end
   end

endmodule
`default_nettype wire

// >>> verif/tccu_chk.sv
// checker: bus handshake, reset and interrupt relations at the tccu_top ports
// assumes one clock CLK, SRST synchronous active high
`timescale 1ns/1ns
`default_nettype none
module tccu_chk(
   // clock, reset, enable
   input wire logic CLK,
   input wire logic SRST,
   input wire logic CE,
   // bus
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [7:0] WB_ADR_I,
   input wire logic [31:0] WB_DAT_O,
   input wire logic WB_ACK_O,
   // outputs
   input wire logic [7:0] PORT4_OUT,
   input wire logic IRQ
);
   default clocking cb @(posedge CLK); endclocking
   sequence s_take;
      CE && WB_CYC_I && WB_STB_I && !WB_ACK_O;
   endsequence
   sequence s_wr_ack;
      WB_WE_I && WB_ACK_O;
   endsequence
   a_ack_after_take: assert property (disable iff (SRST) s_take |=> WB_ACK_O)
      else $error("ack missing after request");
   a_ack_one_cycle: assert property (disable iff (SRST) WB_ACK_O |=> !WB_ACK_O)
      else $error("ack longer than one cycle");
   a_ack_needs_req: assert property (disable iff (SRST) !(WB_CYC_I && WB_STB_I) |=> !WB_ACK_O)
      else $error("ack without request");
   a_upper_half_zero: assert property (disable iff (SRST) WB_ACK_O |-> WB_DAT_O[31:16] == 16'h0000)
      else $error("read data upper half not zero");
   a_unmapped_reads_zero: assert property (disable iff (SRST)
      WB_ACK_O && !WB_WE_I && WB_ADR_I == 8'h40 |-> WB_DAT_O == 32'h00000000)
      else $error("unmapped read not zero");
   a_reset_quiet: assert property (SRST && CE |=> !WB_ACK_O && !IRQ && PORT4_OUT == 8'h00)
      else $error("outputs not cleared by reset");
   a_port_after_reset: assert property ($fell(SRST) |-> (PORT4_OUT == 8'h00) [*2])
      else $error("port moved right after reset");
   // flags only drop by software: an interrupt falls only after a write
   a_irq_fall_by_write: assert property (disable iff (SRST)
      $fell(IRQ) |-> $past(WB_WE_I && WB_ACK_O) || $past(WB_WE_I && WB_ACK_O, 2))
      else $error("interrupt fell without a write");
endmodule
bind tccu_top tccu_chk chk (.CLK(CLK), .SRST(SRST), .CE(CE), .WB_CYC_I(WB_CYC_I),
   .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_DAT_O(WB_DAT_O),
   .WB_ACK_O(WB_ACK_O), .PORT4_OUT(PORT4_OUT), .IRQ(IRQ));
`default_nettype wire

// >>> verif/tccu_cap_src.sv
// far side: drives all four capture lines high for ten cycles per go pulse
// assumes go is one cycle long and synchronous to clk
`timescale 1ns/1ns
`default_nettype none
module tccu_cap_src(
   // clock and request
   input wire logic clk,
   input wire logic go,
   // capture lines
   output logic [3:0] cap_q
);
   logic [3:0] cnt_q = 4'h0;
   initial cap_q = 4'h0;
   always @(posedge clk)
   begin
      cnt_q <= go ? 4'ha : (cnt_q != 4'h0 ? cnt_q - 4'h1 : 4'h0);
      cap_q <= {4{go || cnt_q > 4'h1}};
   end
endmodule
`default_nettype wire

// >>> verif/tccu_tb_top.sv
// testbench: compares, captures, flags and interrupt of tccu_top over wishbone
// assumes timer counts once per clock when run bit is set
`include "tccu_defines.vh"
`timescale 1ns/1ns
`default_nettype none
module tccu_tb_top;
   logic CLK = 1'b0, SRST = 1'b1, CE = 1'b1, WB_CYC_I = 1'b0, WB_STB_I = 1'b0, WB_WE_I = 1'b0;
   logic [7:0] WB_ADR_I = 8'h00;
   logic [3:0] WB_SEL_I = 4'h0;
   logic [31:0] WB_DAT_I = 32'h0, WB_DAT_O, q, c0;
   logic WB_ACK_O, IRQ, go = 1'b0;
   logic [7:0] PORT4_OUT;
   logic [3:0] CAPTURE_IN;
   int fail_count = 0, checks = 0;
   always #10 CLK = ~CLK;
   tccu_top dut (.CLK(CLK), .SRST(SRST), .CE(CE), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
      .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
      .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .CAPTURE_IN(CAPTURE_IN),
      .PORT4_OUT(PORT4_OUT), .IRQ(IRQ));
   tccu_cap_src far (.clk(CLK), .go(go), .cap_q(CAPTURE_IN));
   task finish_test;
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
         fail_count++;
      end
   endtask
   // one classic cycle; entered just after a rising edge
   task wb(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      int n;
      n = 0;
      {WB_CYC_I, WB_STB_I, WB_WE_I, WB_ADR_I, WB_DAT_I, WB_SEL_I} <= {2'b11, we, a, d, s};
      do @(posedge CLK); while (WB_ACK_O !== 1'b1 && ++n < 50);
      if (n >= 50)
      begin
         fail_count++;
         finish_test;
      end
      q = WB_DAT_O;
      {WB_CYC_I, WB_STB_I} <= 2'b00;
      @(posedge CLK);
   endtask
   task rd(input logic [7:0] a, input logic [31:0] exp);
      wb(1'b0, a, 32'h0, 4'h3);
      chk(q, exp);
   endtask
   // interrupt is registered behind the flags, so let two edges pass
   task chk_irq(input logic exp);
      repeat (2) @(posedge CLK);
      #5 chk({31'h0, IRQ}, {31'h0, exp});
      @(posedge CLK);
   endtask
   task test_reset;
      rd(`TCCU_OFS_CMP_A, 32'h0);
      rd(`TCCU_OFS_FLAGS, 32'h0);
      rd(8'h40, 32'h0);
      $display("test reset done");
   endtask
   task test_compare;
      wb(1'b1, `TCCU_OFS_SETEN, 32'hbf, 4'h1);
      wb(1'b1, `TCCU_OFS_CLRTGL, 32'hcf, 4'h1);
      wb(1'b1, `TCCU_OFS_CMP_A, 32'h40, 4'h3);
      wb(1'b1, `TCCU_OFS_CMP_B, 32'h80, 4'h3);
      wb(1'b1, `TCCU_OFS_CMP_C, 32'h60, 4'h3);
      wb(1'b1, `TCCU_OFS_CTRL, 32'h01, 4'h1);
      repeat (200) @(posedge CLK);
      rd(`TCCU_OFS_PORT, 32'h70);
      rd(`TCCU_OFS_FLAGS, 32'h70);
      wb(1'b1, `TCCU_OFS_FLAGS, 32'h70, 4'h1);
      rd(`TCCU_OFS_FLAGS, 32'h0);
      $display("test compare done");
   endtask
   task test_same_match;
      wb(1'b1, `TCCU_OFS_CMP_A, 32'h200, 4'h3);
      wb(1'b1, `TCCU_OFS_CMP_B, 32'h200, 4'h3);
      wb(1'b1, `TCCU_OFS_PORT, 32'h7f, 4'h1);
      repeat (300) @(posedge CLK);
      rd(`TCCU_OFS_PORT, 32'h70);
      rd(`TCCU_OFS_CTRL, 32'h11);
      $display("test same match done");
   endtask
   task test_capture;
      wb(1'b1, `TCCU_OFS_FLAGS, 32'hff, 4'h1);
      wb(1'b1, `TCCU_OFS_EDGE, 32'hc9, 4'h1);
      go <= 1'b1;
      @(posedge CLK);
      go <= 1'b0;
      repeat (20) @(posedge CLK);
      rd(`TCCU_OFS_FLAGS, 32'h0b);
      rd(`TCCU_OFS_CAP2, 32'h0);
      wb(1'b0, `TCCU_OFS_CAP0, 32'h0, 4'h3);
      c0 = q;
      chk(c0 & 32'hffff0000, 32'h0);
      rd(`TCCU_OFS_CAP1, c0 + 32'ha);
      rd(`TCCU_OFS_CAP3, c0 + 32'ha);
      $display("test capture done");
   endtask
   task test_interrupt;
      chk_irq(1'b0);
      wb(1'b1, `TCCU_OFS_MASK, 32'h0b, 4'h1);
      chk_irq(1'b1);
      wb(1'b1, `TCCU_OFS_MASK, 32'h00, 4'h1);
      chk_irq(1'b0);
      wb(1'b1, `TCCU_OFS_CTRL, 32'h41, 4'h1);
      chk_irq(1'b1);
      $display("test interrupt done");
   endtask
   task test_mid_reset;
      wb(1'b1, `TCCU_OFS_CMP_A, 32'h1234, 4'h3);
      SRST <= 1'b1;
      repeat (2) @(posedge CLK);
      SRST <= 1'b0;
      @(posedge CLK);
      rd(`TCCU_OFS_CMP_A, 32'h0);
      rd(`TCCU_OFS_PORT, 32'h0);
      $display("test mid reset done");
   endtask
   initial
   begin
      repeat (8) @(posedge CLK);
      SRST <= 1'b0;
      @(posedge CLK);
      test_reset;
      test_compare;
      test_same_match;
      test_capture;
      test_interrupt;
      test_mid_reset;
      finish_test;
   end
endmodule
`default_nettype wire
